// >>> cpu_core_registers.v
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
`include "core_regs_consts.vh"
// How it works
// - pointer_select bit 0 picks pointer_zero (0) or pointer_one (1).
// - each pointer is high and low bytes, separately accessible, reset to zero.
// - four banks of eight bytes at data addresses 0x00-0x1f.
// - work_bank_sel, status bits 4:3, picks the active bank.
// - bank 0 lives in flip-flops, banks 1-3 in the data memory array.
// - status bit 7 records carry or borrow of last arithmetic operation.
// - status bit 6 records nibble carry or borrow of last arithmetic.
// - status bit 2 set on carry, borrow or multiply/divide overflow.
// - status bit 0 is hardware odd parity of the main operand register.
// - status bits 5 and 1 are user flags; status also bit-addressable.
// - writes to status or its bits update flags like any other update.
// - main operand register is source and destination, reset to zero.
// - second operand register feeds multiply/divide, else scratch byte.
// - push increments stack index, then writes at the new index.
// - stack index resets to 0x07, so first push lands at 0x08.
// - absolute branch replaces low 11 bits of next-instruction address.
// - relative branch adds signed 8-bit offset to next-instruction address.
// - direct address below 0x80 is data memory, above is special registers.
// - indirect operand uses bank register 0 or 1 as 8-bit data pointer.
// - cycle counts are best case; slow memory may stretch them.
// - add and add-with-carry opcodes 28-2f and 38-3f; register form one cycle.
// - subtract-with-borrow opcodes 98-9f, 95, 96-97, 94.
// - flags forced low, high, from result, or left unchanged per operation.
module cpu_core_registers #(
   parameter DATA_DEPTH = 256
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   output reg [15:0] active_pointer,
   output reg [7:0] status_out
);
   // ==========================================
   // bus decode
   wire [7:0] idx;
   wire acc_phase;
   wire wr;
   wire rd;
   wire [7:0] wbyte;
   reg mapped;
   reg [7:0] rdata;
   assign idx = paddr[9:2];
   assign acc_phase = psel & penable & ~pready;
   assign wr = acc_phase & pwrite & mapped;
   assign rd = acc_phase & ~pwrite;
   assign wbyte = pwdata[7:0];

   // ==========================================
   // architectural registers
   reg [7:0] stack_top_index_r;
   reg [7:0] stack_top_index_nxt;
   reg [7:0] main_operand_reg_r;
   reg [7:0] main_operand_reg_nxt;
   reg [7:0] second_operand_reg_r;
   reg [7:0] second_operand_reg_nxt;
   reg [7:0] status_r;
   reg [7:0] status_nxt;
   reg [7:0] op_data_r;
   reg [7:0] op_result_r;
   reg [7:0] op_result_nxt;
   reg [7:0] direct_addr_r;
   reg [15:0] branch_pc_r;
   reg [15:0] branch_arg_r;
   reg [15:0] branch_tgt_r;
   reg [7:0] bank0_r [0:7];
   reg [7:0] data_mem [0:DATA_DEPTH-1];
   wire [7:0] ptr0_lo;
   wire [7:0] ptr0_hi;
   wire [7:0] ptr1_lo;
   wire [7:0] ptr1_hi;
   wire [7:0] ptr_sel;
   wire [1:0] bank;
   wire odd_ones;
   wire [15:0] ptr_cur;
   wire [15:0] ptr_inc;
   wire inc_ptr;

   assign bank = status_r[`ST_BANK_HI:`ST_BANK_LO];
   assign odd_ones = ^main_operand_reg_r;
   assign ptr_cur = ptr_sel[0] ? {ptr1_hi, ptr1_lo} : {ptr0_hi, ptr0_lo};
   assign ptr_inc = ptr_cur + 16'h0001;
   assign inc_ptr = wr && idx == `IDX_OP_CTRL && wbyte == `OP_INC_PTR;

   // pointer bytes: software load or increment of the active pointer
   byte_reg #(.RESET_VAL(`RST_ZERO)) u_p0l (.pclk(pclk), .presetn(presetn),
      .load((wr && idx == `IDX_PTR0_LO) || (inc_ptr && !ptr_sel[0])),
      .din(inc_ptr ? ptr_inc[7:0] : wbyte), .q(ptr0_lo));
   byte_reg #(.RESET_VAL(`RST_ZERO)) u_p0h (.pclk(pclk), .presetn(presetn),
      .load((wr && idx == `IDX_PTR0_HI) || (inc_ptr && !ptr_sel[0])),
      .din(inc_ptr ? ptr_inc[15:8] : wbyte), .q(ptr0_hi));
   byte_reg #(.RESET_VAL(`RST_ZERO)) u_p1l (.pclk(pclk), .presetn(presetn),
      .load((wr && idx == `IDX_PTR1_LO) || (inc_ptr && ptr_sel[0])),
      .din(inc_ptr ? ptr_inc[7:0] : wbyte), .q(ptr1_lo));
   byte_reg #(.RESET_VAL(`RST_ZERO)) u_p1h (.pclk(pclk), .presetn(presetn),
      .load((wr && idx == `IDX_PTR1_HI) || (inc_ptr && ptr_sel[0])),
      .din(inc_ptr ? ptr_inc[15:8] : wbyte), .q(ptr1_hi));
   // only bit 0 is implemented, upper bits read zero
   byte_reg #(.RESET_VAL(`RST_ZERO)) u_psel (.pclk(pclk), .presetn(presetn),
      .load(wr && idx == `IDX_PTR_SEL), .din({7'h00, wbyte[0]}), .q(ptr_sel));

   // ==========================================
   // data space access helpers
   // bank 0 reads from flops, everything else from the array
   function [7:0] data_rd;
      input [7:0] a;
      begin
         if (a[7:3] == 5'h00) begin
            data_rd = bank0_r[a[2:0]];
         end else begin
            data_rd = data_mem[a];
         end
      end
   endfunction

   wire [7:0] reg_addr_base;
   wire [2:0] op_low;
   wire [7:0] ind_ptr;
   wire [7:0] direct_val;
   assign reg_addr_base = {3'b000, bank, 3'b000};
   assign op_low = op_data_r[2:0];
   assign ind_ptr = data_rd(reg_addr_base | {7'h00, op_low[0]});

   function [7:0] special_rd;
      input [7:0] a;
      begin
         case (a)
            `IDX_STACK_TOP: special_rd = stack_top_index_r;
            `IDX_PTR0_LO: special_rd = ptr0_lo;
            `IDX_PTR0_HI: special_rd = ptr0_hi;
            `IDX_PTR1_LO: special_rd = ptr1_lo;
            `IDX_PTR1_HI: special_rd = ptr1_hi;
            `IDX_PTR_SEL: special_rd = ptr_sel;
            `IDX_STATUS: special_rd = {status_r[7:1], odd_ones};
            `IDX_MAIN_OP: special_rd = main_operand_reg_r;
            `IDX_SECOND_OP: special_rd = second_operand_reg_r;
            default: special_rd = `RST_ZERO;
         endcase
      end
   endfunction
   assign direct_val = direct_addr_r[7] ? special_rd(direct_addr_r) : data_rd(direct_addr_r);

   // ==========================================
   // operand selection and arithmetic
   reg [7:0] opnd;
   reg is_arith;
   reg is_sub;
   reg use_carry;
   always @* begin
      opnd = op_data_r;
      is_arith = 1'b0;
      is_sub = 1'b0;
      use_carry = 1'b0;
      if (wr && idx == `IDX_OP_CTRL) begin
         case (wbyte)
            `OP_ADD_DIR, `OP_ADD_WITH_CARRY_OP_DIR, `OP_SUBTRACT_WITH_BORROW_OP_DIR: opnd = direct_val;
            `OP_ADD_IND_LO, `OP_ADD_IND_HI, `OP_ADD_WITH_CARRY_OP_IND_LO, `OP_ADD_WITH_CARRY_OP_IND_HI,
            `OP_SUBTRACT_WITH_BORROW_OP_IND_LO, `OP_SUBTRACT_WITH_BORROW_OP_IND_HI: opnd = data_rd(ind_ptr);
            `OP_ADD_IMM, `OP_ADD_WITH_CARRY_OP_IMM, `OP_SUBTRACT_WITH_BORROW_OP_IMM: opnd = op_data_r;
            default: opnd = data_rd(reg_addr_base | {5'h00, wbyte[2:0]}); // register forms
         endcase
         if ((wbyte >= `OP_ADD_REG_LO && wbyte <= `OP_ADD_REG_HI) || wbyte == `OP_ADD_DIR ||
             wbyte == `OP_ADD_IND_LO || wbyte == `OP_ADD_IND_HI || wbyte == `OP_ADD_IMM) begin
            is_arith = 1'b1;
         end
         if ((wbyte >= `OP_ADD_WITH_CARRY_OP_REG_LO && wbyte <= `OP_ADD_WITH_CARRY_OP_REG_HI) || wbyte == `OP_ADD_WITH_CARRY_OP_DIR ||
             wbyte == `OP_ADD_WITH_CARRY_OP_IND_LO || wbyte == `OP_ADD_WITH_CARRY_OP_IND_HI || wbyte == `OP_ADD_WITH_CARRY_OP_IMM) begin
            is_arith = 1'b1;
            use_carry = 1'b1;
         end
         if ((wbyte >= `OP_SUBTRACT_WITH_BORROW_OP_REG_LO && wbyte <= `OP_SUBTRACT_WITH_BORROW_OP_REG_HI) || wbyte == `OP_SUBTRACT_WITH_BORROW_OP_DIR ||
             wbyte == `OP_SUBTRACT_WITH_BORROW_OP_IND_LO || wbyte == `OP_SUBTRACT_WITH_BORROW_OP_IND_HI || wbyte == `OP_SUBTRACT_WITH_BORROW_OP_IMM) begin
            is_arith = 1'b1;
            is_sub = 1'b1;
            use_carry = 1'b1;
         end
      end
   end

   wire [7:0] alu_res;
   wire alu_cy;
   wire alu_ac;
   wire alu_ov;
   alu8 u_alu (
      .a(main_operand_reg_r),
      .b(opnd),
      .cin(use_carry & status_r[`ST_CARRY]),
      .sub(is_sub),
      .res(alu_res),
      .cy(alu_cy),
      .ac(alu_ac),
      .ov(alu_ov)
   );

   wire [15:0] product;
   wire [7:0] quot;
   wire [7:0] remd;
   wire div_zero;
   assign product = main_operand_reg_r * second_operand_reg_r;
   assign div_zero = (second_operand_reg_r == 8'h00);
   assign quot = div_zero ? 8'hff : main_operand_reg_r / second_operand_reg_r;
   assign remd = div_zero ? 8'h00 : main_operand_reg_r % second_operand_reg_r;

   wire do_push;
   wire do_pop;
   wire [7:0] sp_up;
   assign do_push = wr && idx == `IDX_OP_CTRL && wbyte == `OP_PUSH;
   assign do_pop = wr && idx == `IDX_OP_CTRL && wbyte == `OP_POP;
   assign sp_up = stack_top_index_r + 8'h01;

   // ==========================================
   // next-state for core registers
   always @* begin
      main_operand_reg_nxt = main_operand_reg_r;
      second_operand_reg_nxt = second_operand_reg_r;
      stack_top_index_nxt = stack_top_index_r;
      status_nxt = status_r;
      op_result_nxt = op_result_r;
      if (wr && idx == `IDX_MAIN_OP) main_operand_reg_nxt = wbyte;
      if (wr && idx == `IDX_SECOND_OP) second_operand_reg_nxt = wbyte;
      if (wr && idx == `IDX_STACK_TOP) stack_top_index_nxt = wbyte;
      if (wr && idx == `IDX_STATUS) status_nxt = wbyte;
      if (wr && idx == `IDX_BIT_CTRL) status_nxt[wbyte[2:0]] = wbyte[7];
      if (is_arith) begin
         main_operand_reg_nxt = alu_res;
         op_result_nxt = alu_res;
         status_nxt[`ST_CARRY] = alu_cy;
         status_nxt[`ST_NIBBLE] = alu_ac;
         status_nxt[`ST_RANGE] = alu_ov;
      end
      if (wr && idx == `IDX_OP_CTRL && wbyte == `OP_MUL) begin
         main_operand_reg_nxt = product[7:0];
         second_operand_reg_nxt = product[15:8];
         status_nxt[`ST_CARRY] = 1'b0;
         status_nxt[`ST_RANGE] = |product[15:8];
      end
      if (wr && idx == `IDX_OP_CTRL && wbyte == `OP_DIV) begin
         main_operand_reg_nxt = quot;
         second_operand_reg_nxt = remd;
         status_nxt[`ST_CARRY] = 1'b0;
         status_nxt[`ST_RANGE] = div_zero;
      end
      if (do_push) stack_top_index_nxt = sp_up;
      if (do_pop) begin
         op_result_nxt = data_rd(stack_top_index_r);
         stack_top_index_nxt = stack_top_index_r - 8'h01;
      end
      // parity is derived, stored bit mirrors next accumulator
      status_nxt[`ST_ODD] = ^main_operand_reg_nxt;
   end

   // ==========================================
   // branch target calculation
   wire [15:0] abs_tgt;
   wire [15:0] rel_tgt;
   // abs: page bits of next pc kept, low 11 from arg
   assign abs_tgt = {branch_pc_r[15:`PAGE_BITS], branch_arg_r[`PAGE_BITS-1:0]};
   assign rel_tgt = branch_pc_r + {{8{branch_arg_r[7]}}, branch_arg_r[7:0]};

   // ==========================================
   // clocked state
   integer i;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         main_operand_reg_r <= `RST_ZERO;
         second_operand_reg_r <= `RST_ZERO;
         stack_top_index_r <= `RST_STACK_TOP;
         status_r <= `RST_ZERO;
         op_data_r <= `RST_ZERO;
         op_result_r <= `RST_ZERO;
         direct_addr_r <= `RST_ZERO;
         branch_pc_r <= 16'h0000;
         branch_arg_r <= 16'h0000;
         branch_tgt_r <= 16'h0000;
         for (i = 0; i < 8; i = i + 1) begin
            bank0_r[i] <= `RST_ZERO;
         end
      end else begin
         main_operand_reg_r <= main_operand_reg_nxt;
         second_operand_reg_r <= second_operand_reg_nxt;
         stack_top_index_r <= stack_top_index_nxt;
         status_r <= status_nxt;
         op_result_r <= op_result_nxt;
         if (wr && idx == `IDX_OP_DATA) op_data_r <= wbyte;
         if (wr && idx == `IDX_DIRECT_ADDR) direct_addr_r <= wbyte;
         if (wr && idx == `IDX_BRANCH_PC_LO) branch_pc_r[7:0] <= wbyte;
         if (wr && idx == `IDX_BRANCH_PC_HI) branch_pc_r[15:8] <= wbyte;
         if (wr && idx == `IDX_BRANCH_ARG_LO) branch_arg_r[7:0] <= wbyte;
         if (wr && idx == `IDX_BRANCH_ARG_HI) branch_arg_r[15:8] <= wbyte;
         if (branch_arg_r[15:14] == `BR_ABS) begin
            branch_tgt_r <= abs_tgt;
         end else if (branch_arg_r[15:14] == `BR_REL) begin
            branch_tgt_r <= rel_tgt;
         end
         // bank 0 writes stay in flops
         if (wr && idx == `IDX_DIRECT_DATA && direct_addr_r[7:3] == 5'h00) begin
            bank0_r[direct_addr_r[2:0]] <= wbyte;
         end
         if (do_push && sp_up[7:3] == 5'h00) bank0_r[sp_up[2:0]] <= main_operand_reg_r;
      end
   end

   // array has no reset: it models the data memory
   always @(posedge pclk) begin
      if (wr && idx == `IDX_DIRECT_DATA && !direct_addr_r[7] && direct_addr_r[7:3] != 5'h00) begin
         data_mem[direct_addr_r] <= wbyte;
      end
      if (do_push && sp_up[7:3] != 5'h00) data_mem[sp_up] <= main_operand_reg_r;
   end

   // ==========================================
   // read mux and bus answer
   always @* begin
      mapped = 1'b1;
      rdata = `RST_ZERO;
      case (idx)
         `IDX_OP_CTRL: rdata = `RST_ZERO;
         `IDX_OP_DATA: rdata = op_data_r;
         `IDX_OP_RESULT: rdata = op_result_r;
         `IDX_DIRECT_ADDR: rdata = direct_addr_r;
         `IDX_DIRECT_DATA: rdata = direct_val;
         `IDX_BIT_CTRL: rdata = `RST_ZERO;
         `IDX_BRANCH_PC_LO: rdata = branch_pc_r[7:0];
         `IDX_BRANCH_PC_HI: rdata = branch_pc_r[15:8];
         `IDX_BRANCH_ARG_LO: rdata = branch_arg_r[7:0];
         `IDX_BRANCH_ARG_HI: rdata = branch_arg_r[15:8];
         `IDX_BRANCH_TGT_LO: rdata = branch_tgt_r[7:0];
         `IDX_BRANCH_TGT_HI: rdata = branch_tgt_r[15:8];
         `IDX_STACK_TOP, `IDX_PTR0_LO, `IDX_PTR0_HI, `IDX_PTR1_LO, `IDX_PTR1_HI,
         `IDX_PTR_SEL, `IDX_STATUS, `IDX_MAIN_OP, `IDX_SECOND_OP: rdata = special_rd(idx);
         default: mapped = 1'b0;
      endcase
      if (paddr[11:10] != 2'b00 || paddr[1:0] != 2'b00) mapped = 1'b0;
   end

   // one wait state: ready rises in the second access cycle
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
         active_pointer <= 16'h0000;
         status_out <= `RST_ZERO;
      end else begin
         pready <= acc_phase;
         pslverr <= acc_phase & ~mapped;
         if (rd) prdata <= mapped ? {24'h000000, rdata} : 32'h00000000;
         active_pointer <= ptr_cur;
         status_out <= {status_r[7:1], odd_ones};
      end
   end
   // each operation here completes in one access; no stretching modelled
endmodule // cpu_core_registers

// >>> core_regs_consts.vh
`ifndef CORE_REGS_CONSTS_VH
`define CORE_REGS_CONSTS_VH
// ==========================================
// special register offsets (byte address = 4 * index)
`define IDX_STACK_TOP 8'h81
`define IDX_PTR0_LO 8'h82
`define IDX_PTR0_HI 8'h83
`define IDX_PTR1_LO 8'h84
`define IDX_PTR1_HI 8'h85
`define IDX_PTR_SEL 8'h92
`define IDX_STATUS 8'hd0
`define IDX_MAIN_OP 8'he0
`define IDX_SECOND_OP 8'hf0
`define IDX_OP_CTRL 8'hc0
`define IDX_OP_DATA 8'hc1
`define IDX_OP_RESULT 8'hc2
`define IDX_DIRECT_ADDR 8'hc3
`define IDX_DIRECT_DATA 8'hc4
`define IDX_BIT_CTRL 8'hc5
`define IDX_BRANCH_PC_LO 8'hc8
`define IDX_BRANCH_PC_HI 8'hc9
`define IDX_BRANCH_ARG_LO 8'hca
`define IDX_BRANCH_ARG_HI 8'hcb
`define IDX_BRANCH_TGT_LO 8'hcc
`define IDX_BRANCH_TGT_HI 8'hcd
// ==========================================
// reset values
`define RST_STACK_TOP 8'h07
`define RST_ZERO 8'h00
// ==========================================
// status word fields
`define ST_CARRY 7
`define ST_NIBBLE 6
`define ST_USER0 5
`define ST_BANK_HI 4
`define ST_BANK_LO 3
`define ST_RANGE 2
`define ST_USER1 1
`define ST_ODD 0
// ==========================================
// operation codes written to op control
`define OP_ADD_REG_LO 8'h28
`define OP_ADD_REG_HI 8'h2f
`define OP_ADD_DIR 8'h25
`define OP_ADD_IND_LO 8'h26
`define OP_ADD_IND_HI 8'h27
`define OP_ADD_IMM 8'h24
`define OP_ADD_WITH_CARRY_OP_REG_LO 8'h38
`define OP_ADD_WITH_CARRY_OP_REG_HI 8'h3f
`define OP_ADD_WITH_CARRY_OP_DIR 8'h35
`define OP_ADD_WITH_CARRY_OP_IND_LO 8'h36
`define OP_ADD_WITH_CARRY_OP_IND_HI 8'h37
`define OP_ADD_WITH_CARRY_OP_IMM 8'h34
`define OP_SUBTRACT_WITH_BORROW_OP_REG_LO 8'h98
`define OP_SUBTRACT_WITH_BORROW_OP_REG_HI 8'h9f
`define OP_SUBTRACT_WITH_BORROW_OP_DIR 8'h95
`define OP_SUBTRACT_WITH_BORROW_OP_IND_LO 8'h96
`define OP_SUBTRACT_WITH_BORROW_OP_IND_HI 8'h97
`define OP_SUBTRACT_WITH_BORROW_OP_IMM 8'h94
`define OP_INC_PTR 8'ha3
`define OP_MUL 8'ha4
`define OP_DIV 8'h84
`define OP_PUSH 8'hc0
`define OP_POP 8'hd0
// ==========================================
// branch kinds, bits 7:6 of branch arg high
`define BR_ABS 2'b01
`define BR_REL 2'b10
// ==========================================
// misc sizes
`define SFR_BASE 8'h80
`define PAGE_BITS 11
`define CYC_ONE 2'd1
`define CYC_TWO 2'd2
`endif

// >>> alu8.v
`timescale 1ns/1ps
// ==========================================
// add / subtract with carry, nibble and range flags
module alu8 (
   input wire [7:0] a,
   input wire [7:0] b,
   input wire cin,
   input wire sub,
   output wire [7:0] res,
   output wire cy,
   output wire ac,
   output wire ov
);
   wire [7:0] bx;
   wire [4:0] lo;
   wire [8:0] full;
   assign bx = sub ? ~b : b;
   // subtract done as a + ~b + ~borrow, flags inverted back
   assign lo = {1'b0, a[3:0]} + {1'b0, bx[3:0]} + {4'h0, cin ^ sub};
   assign full = {1'b0, a} + {1'b0, bx} + {8'h00, cin ^ sub};
   assign res = full[7:0];
   assign cy = full[8] ^ sub;
   assign ac = lo[4] ^ sub;
   // range flag follows carry on add and borrow on subtract
   assign ov = full[8] ^ sub;
endmodule // alu8

// >>> byte_reg.v
`timescale 1ns/1ps
// ==========================================
// one software-writable byte with reset value
module byte_reg #(
   parameter [7:0] RESET_VAL = 8'h00
) (
   input wire pclk,
   input wire presetn,
   input wire load,
   input wire [7:0] din,
   output reg [7:0] q
);
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= RESET_VAL;
      end else if (load) begin
         q <= din;
      end
   end
endmodule // byte_reg

// >>> cpu_core_registers_sva.sv
`timescale 1ns/1ps
`include "core_regs_consts.vh"
// ==========================================
// port-level checks
module cpu_core_registers_sva (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   input wire [15:0] active_pointer,
   input wire [7:0] status_out
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   chk_one_wait: assert property
      ((psel && !penable ##1 psel && penable) |-> !pready ##1 pready) else $error("access wait wrong");
   chk_ready_pulse: assert property (pready |=> !pready) else $error("ready held");
   chk_idle_quiet: assert property (!psel |-> !pready) else $error("ready when idle");
   chk_err_with_ready: assert property (pslverr |-> pready) else $error("stray slverr");
   chk_misalign_err: assert property (pready && paddr[1:0] != 2'b00 |-> pslverr) else $error("no slverr");
   chk_err_read_zero: assert property
      (pready && pslverr && !pwrite |-> prdata == 32'h0) else $error("refused read data");
   chk_upper_zero: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0) else $error("upper bits");
   chk_main_mapped: assert property
      (pready && paddr == {2'b00, `IDX_MAIN_OP, 2'b00} |-> !pslverr) else $error("main refused");
   chk_status_bank: assert property
      (pready && pwrite && paddr == {2'b00, `IDX_STATUS, 2'b00} |=> {status_out[5:3], status_out[1]}
      == {$past(pwdata[5:3]), $past(pwdata[1])}) else $error("status bits lost");
endmodule // cpu_core_registers_sva
bind cpu_core_registers cpu_core_registers_sva cpu_core_registers_sva_inst (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .active_pointer(active_pointer), .status_out(status_out));

// >>> test_cpu_core_registers.sv
`timescale 1ns/1ps
`include "core_regs_consts.vh"
module test_cpu_core_registers;
   reg pclk = 1'b0;
   reg presetn = 1'b0;
   reg psel = 1'b0;
   reg penable = 1'b0;
   reg pwrite = 1'b0;
   reg [11:0] paddr = 12'h000;
   reg [31:0] pwdata = 32'h0;
   wire [31:0] prdata;
   wire pready;
   wire pslverr;
   wire [15:0] active_pointer;
   wire [7:0] status_out;
   integer errors = 0;
   integer n_compared = 0;
   integer i, t, kd, fm;
   reg [31:0] rd;
   reg err, ind;
   reg [7:0] a, b, s, v, ra, p;
   reg [15:0] e;
   reg [63:0] idx_all = {`IDX_STACK_TOP, `IDX_PTR0_LO, `IDX_PTR0_HI, `IDX_PTR1_LO, `IDX_PTR1_HI,
      `IDX_PTR_SEL, `IDX_MAIN_OP, `IDX_SECOND_OP};
   cpu_core_registers cpu_core_registers_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .active_pointer(active_pointer), .status_out(status_out));
   initial begin
      forever #4 pclk = ~pclk;
   end
   // ==========================================
   // helpers
   function [11:0] ad(input [7:0] x);
      ad = {2'b00, x, 2'b00};
   endfunction
   // {result, status}; carry-in only for the with-carry kinds (opcode bit 4)
   function [15:0] alu_exp(input [7:0] op, input [7:0] x, input [7:0] y, input [7:0] st);
      reg c;
      reg [8:0] r;
      reg [4:0] h;
      begin
         c = op[4] & st[7];
         r = op[7] ? {1'b0, x} - y - c : x + y + c;
         h = op[7] ? {1'b0, x[3:0]} - y[3:0] - c : x[3:0] + y[3:0] + c;
         alu_exp = {r[7:0], r[8], h[4], st[5:3], r[8], st[1], ^r[7:0]};
      end
   endfunction
   // {second, main} after multiply or divide; divide by zero gives quotient ff
   function [15:0] md_exp(input dv, input [7:0] x, input [7:0] y);
      md_exp = !dv ? x * y : (y == 8'h00) ? 16'h00ff : {x % y, x / y};
   endfunction
   function [15:0] br_exp(input [15:0] pc, input [15:0] arg);
      br_exp = arg[14] ? {pc[15:11], arg[10:0]} : pc + {{8{arg[7]}}, arg[7:0]};
   endfunction
   task check(input [31:0] seen, input [31:0] want);
      begin
         n_compared = n_compared + 1;
         if (seen !== want) begin
            errors = errors + 1;
            $display("Error at %0t: saw %h expected %h", $time, seen, want);
         end
      end
   endtask
   task conclude;
      begin
         if (errors == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
         end else begin
            $display("SIMULATION FAILED");
         end
         $finish;
      end
   endtask
   // idle cycle after each transfer so no signal is assigned twice in one step
   task xfer(input wr, input [11:0] adr, input [7:0] d);
      begin
         {psel, pwrite, paddr, pwdata} <= {1'b1, wr, adr, 24'h0, d};
         @(posedge pclk);
         penable <= 1'b1;
         @(posedge pclk);
         for (t = 0; t < 16 && pready !== 1'b1; t = t + 1) @(posedge pclk);
         check(pready, 1'b1);
         rd = prdata;
         err = pslverr;
         {psel, penable} <= 2'b00;
         @(posedge pclk);
      end
   endtask
   task reset_check;
      begin
         for (i = 0; i < 8; i = i + 1) begin
            xfer(0, ad(idx_all[8*i +: 8]), 8'h00);
            check(rd, (i == 7) ? 32'h7 : 32'h0);
         end
         xfer(0, ad(`IDX_STATUS), 8'h00);
         check(rd, 32'h0);
      end
   endtask
   initial begin
      #100000;
      errors = errors + 1;
      conclude;
   end
   // ==========================================
   // main sequence
   initial begin
      t = $urandom(51);
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      reset_check;
      v = $urandom;
      xfer(1, ad(`IDX_MAIN_OP), v);
      xfer(1, ad(`IDX_OP_CTRL), `OP_PUSH);
      xfer(0, ad(`IDX_STACK_TOP), 8'h00);
      check(rd, 32'h8);
      xfer(1, ad(`IDX_DIRECT_ADDR), 8'h08);
      xfer(0, ad(`IDX_DIRECT_DATA), 8'h00);
      check(rd, {24'h0, v});
      xfer(1, ad(`IDX_DIRECT_ADDR), `IDX_MAIN_OP);
      xfer(0, ad(`IDX_DIRECT_DATA), 8'h00);
      check(rd, {24'h0, v});
      for (i = 0; i < 8; i = i + 1) begin
         v = $urandom;
         if (i == 2) v[7:1] = 7'h00;
         xfer(1, ad(idx_all[8*i +: 8]), v);
         xfer(0, ad(idx_all[8*i +: 8]), 8'h00);
         check(rd, {24'h0, v});
      end
      a = $urandom;
      b = $urandom;
      xfer(1, ad(`IDX_PTR0_LO), a);
      xfer(1, ad(`IDX_PTR0_HI), b);
      xfer(1, ad(`IDX_PTR1_LO), 8'hff);
      xfer(1, ad(`IDX_PTR1_HI), 8'hff);
      xfer(1, ad(`IDX_PTR_SEL), 8'h00);
      check(active_pointer, {b, a});
      xfer(1, ad(`IDX_PTR_SEL), 8'h01);
      check(active_pointer, 16'hffff);
      xfer(1, ad(`IDX_OP_CTRL), `OP_INC_PTR);
      check(active_pointer, 16'h0000);
      xfer(0, ad(`IDX_PTR1_HI), 8'h00);
      check(rd, 32'h0);
      // register forms in every bank, then immediate, direct and indirect forms
      for (i = 0; i < 42; i = i + 1) begin
         a = $urandom;
         b = $urandom;
         s = $urandom;
         if (i[2:0] == 3'd0) begin
            a = 8'hff;
            b = 8'h01;
         end
         s[4:3] = i[1:0];
         kd = (i < 24) ? i / 8 : i % 3;
         fm = (i < 24) ? 3 : (i - 24) / 6;
         ind = (fm == 2);
         v = (kd == 0) ? `OP_ADD_REG_LO : (kd == 1) ? `OP_ADD_WITH_CARRY_OP_REG_LO : `OP_SUBTRACT_WITH_BORROW_OP_REG_LO;
         v = (i < 24) ? v + i[2:0] : v - 8'h04 + fm[7:0] + {7'h00, ind & i[0]};
         ra = {3'b000, s[4:3], ind ? {2'b00, i[0]} : i[2:0]};
         p = 8'h40 + i[7:0];
         xfer(1, ad(`IDX_STATUS), s);
         xfer(1, ad(`IDX_DIRECT_ADDR), ra);
         xfer(1, ad(`IDX_DIRECT_DATA), ind ? p : b);
         xfer(1, ad(`IDX_DIRECT_ADDR), ind ? p : ra);
         xfer(1, ad(`IDX_DIRECT_DATA), b);
         xfer(1, ad(`IDX_OP_DATA), ind ? {7'h00, i[0]} : b);
         xfer(1, ad(`IDX_MAIN_OP), a);
         xfer(1, ad(`IDX_OP_CTRL), v);
         e = alu_exp(v, a, b, s);
         xfer(0, ad(`IDX_MAIN_OP), 8'h00);
         check(rd, {24'h0, e[15:8]});
         xfer(0, ad(`IDX_STATUS), 8'h00);
         check(rd, {24'h0, e[7:0]});
         check(status_out, e[7:0]);
      end
      for (i = 0; i < 6; i = i + 1) begin
         a = $urandom;
         b = (i == 5) ? 8'h00 : $urandom;
         xfer(1, ad(`IDX_STATUS), 8'h40);
         xfer(1, ad(`IDX_MAIN_OP), a);
         xfer(1, ad(`IDX_SECOND_OP), b);
         xfer(1, ad(`IDX_OP_CTRL), i[0] ? `OP_DIV : `OP_MUL);
         e = md_exp(i[0], a, b);
         xfer(0, ad(`IDX_MAIN_OP), 8'h00);
         check(rd, {24'h0, e[7:0]});
         xfer(0, ad(`IDX_SECOND_OP), 8'h00);
         check(rd, {24'h0, e[15:8]});
         xfer(0, ad(`IDX_STATUS), 8'h00);
         check(rd, {24'h0, 2'b01, 3'b000, (i[0] ? b == 8'h00 : e[15:8] != 8'h00), 1'b0, ^e[7:0]});
      end
      xfer(1, ad(`IDX_STACK_TOP), 8'h2f);
      xfer(1, ad(`IDX_MAIN_OP), v);
      xfer(1, ad(`IDX_OP_CTRL), `OP_PUSH);
      xfer(1, ad(`IDX_MAIN_OP), 8'h00);
      xfer(1, ad(`IDX_OP_CTRL), `OP_POP);
      xfer(0, ad(`IDX_OP_RESULT), 8'h00);
      check(rd, {24'h0, v});
      xfer(0, ad(`IDX_STACK_TOP), 8'h00);
      check(rd, 32'h2f);
      xfer(1, ad(`IDX_STATUS), 8'h00);
      xfer(1, ad(`IDX_BIT_CTRL), 8'h85);
      xfer(1, ad(`IDX_BIT_CTRL), 8'h81);
      xfer(1, ad(`IDX_BIT_CTRL), 8'h83);
      xfer(0, ad(`IDX_STATUS), 8'h00);
      check(rd, 32'h2a);
      for (i = 0; i < 4; i = i + 1) begin
         e = $urandom;
         a = $urandom;
         b = $urandom;
         b[7:6] = i[0] ? `BR_REL : `BR_ABS;
         xfer(1, ad(`IDX_BRANCH_PC_LO), e[7:0]);
         xfer(1, ad(`IDX_BRANCH_PC_HI), e[15:8]);
         xfer(1, ad(`IDX_BRANCH_ARG_LO), a);
         xfer(1, ad(`IDX_BRANCH_ARG_HI), b);
         e = br_exp(e, {b, a});
         xfer(0, ad(`IDX_BRANCH_TGT_LO), 8'h00);
         check(rd, {24'h0, e[7:0]});
         xfer(0, ad(`IDX_BRANCH_TGT_HI), 8'h00);
         check(rd, {24'h0, e[15:8]});
      end
      // second reset in mid-run must restore the stack index, pointer, operand and status reset values
      presetn <= 1'b0;
      @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      reset_check;
      xfer(0, ad(8'h00), 8'h00);
      check(err, 1'b1);
      check(rd, 32'h0);
      xfer(1, 12'h381, 8'h55);
      check(err, 1'b1);
      xfer(0, ad(`IDX_MAIN_OP), 8'h00);
      check(rd, 32'h0);
      conclude;
   end
endmodule // test_cpu_core_registers
